// *** core/scc_pkg.sv ***
// Package for the serial unit common core: modes, widths, timing figures.
// Assumes a single 25 MHz clock; used as scc_pkg::name, never imported.
package scc_pkg;

    // ========================================================
    // Address comparator modes
    typedef enum logic [1:0] {
        SCC_MATCH_MASK  = 2'h0,     // One address with a mask
        SCC_MATCH_TWO   = 2'h1,     // Two distinct addresses
        SCC_MATCH_RANGE = 2'h2      // Inclusive range, mask is upper end
    } scc_match_t;

    // ========================================================
    // Sync handshake states (Gray order along the path)
    typedef enum logic [1:0] {
        SCC_SYNC_IDLE = 2'b00,      // Nothing pending
        SCC_SYNC_REQ  = 2'b01,      // Toggle sent, waiting for echo
        SCC_SYNC_ACK  = 2'b11       // Echo seen, finishing
    } scc_sync_t;

    // ========================================================
    // Widths and reset values
    localparam int          SCC_ADDR_W      = 8;
    localparam int          SCC_BAUD_W      = 16;
    localparam int          SCC_CPF_W       = 16;
    localparam logic [15:0] SCC_BAUD_RST    = 16'h0000;
    localparam logic [7:0]  SCC_ADDR_RST    = 8'h00;
    localparam logic [7:0]  SCC_SEVEN_MASK  = 8'h7F;

    // ========================================================
    // Baud relation: cycles per frame = base + baud/step
    // Ten-bit frame gives 160 cycles at settings up to 406
    localparam logic [15:0] SCC_CPF_PER_BIT = 16'h0010;
    localparam logic [15:0] SCC_BAUD_STEP   = 16'h0197;  // 407 per step
    localparam int          SCC_CPF_MAX     = 31969;     // Top setting
    localparam logic [15:0] SCC_BAUD_TOP    = 16'hFEB8;  // Top baud value
    localparam logic [15:0] SCC_CPF_RST     = 16'h0000;  // Frame length reset

    // ========================================================
    // Synchroniser depth
    localparam int          SCC_SYNC_STAGES = 2;

endpackage

// *** core/scc_sync_bit.sv ***
// Two-flop level synchroniser, parameterised width.
// Assumes the input is a level from another domain, held long enough.
`timescale 1ns/10ps
`default_nettype none

module scc_sync_bit #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstSyncB,
    // Data
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    // ========================================================
    // Stages
    logic [W-1:0] meta;             // First stage, read only by sync_out

    // Register both stages; reset to zero
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// *** core/scc_common_core.sv ***
// Common core of the serial unit: reset, debug halt, write lock,
// cross-domain config sync, baud-to-frame-length relation, address match.
// Assumes rst_b is async; core-domain handshake echoes the sync toggle.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Master mode needs core generic clock running.
// - Slow clock only for selected functions.
// - Cross-domain writes go through a synchroniser.
// - DMA request lines driven; controller preconfigured.
// - One interrupt line; controller preconfigured.
// - Runs in debug halt unless told halt.
// - Lockable writes, except flags, status, data.
// - Debugger writes bypass the lock.
// - Frame length counts data, start, stop.
// - Settings 0 to 406 give 160 cycles.
// - Three match modes, seven or eight bits.
// - Mask bits excluded from address comparison.
// - Zero mask exact, all-ones accepts all.
// - Two-address mode matches either value.
module scc_common_core #(
    parameter int ADDR_W = scc_pkg::SCC_ADDR_W,
    parameter int BAUD_W = scc_pkg::SCC_BAUD_W
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Clock presence
    input  wire logic              coreClkOn,     // Core generic clock runs
    input  wire logic              slowClkOn,     // Slow generic clock runs
    input  wire logic              masterMode,    // Unit acts as bus master
    input  wire logic              slowNeeded,    // Mode uses slow clock
    // Debug
    input  wire logic              cpuHalted,     // Processor in debug halt
    input  wire logic              dbgRunStop,    // Halt while debugging
    // Register write port
    input  wire logic              wrEn,          // Write strobe
    input  wire logic              wrFromDebug,   // Write from debugger
    input  wire logic              wrProtected,   // Register lockable
    input  wire logic              lockOn,        // Access guard lock set
    input  wire logic              wrBaud,        // Target: baud setting
    input  wire logic              wrAddr,        // Target: match config
    input  wire logic [15:0]       wrData,        // Write data
    output var  logic              wrRefused,     // Write blocked pulse
    // Sync echo from core clock domain
    input  wire logic              syncEcho,      // Toggle echoed back
    output var  logic              syncToggle,    // Toggle toward core
    output var  logic              syncBusy,      // Sync in progress
    // Frame format
    input  wire logic [3:0]        dataBits,      // Data bits per frame
    input  wire logic [1:0]        framingBits,   // Start + first stop
    output var  logic [15:0]       cyclesPerFrame,// Reference cycles
    // Address match
    input  wire scc_pkg::scc_match_t matchMode,
    input  wire logic              sevenBit,      // 7-bit comparison
    input  wire logic              addrValid,     // Received address
    input  wire logic [ADDR_W-1:0] rxAddr,
    output var  logic              addrMatch,     // Registered result
    // Events toward the system
    input  wire logic              dmaRxEvt,
    input  wire logic              dmaTxEvt,
    input  wire logic              irqEvt,
    output var  logic              dmaRxReq,
    output var  logic              dmaTxReq,
    output var  logic              irqReq,
    // Status
    output var  logic              running,       // Core may operate
    output var  logic [BAUD_W-1:0] baudValue,     // Active baud setting
    output var  logic [ADDR_W-1:0] matchAddr,
    output var  logic [ADDR_W-1:0] matchMask
);

    // ========================================================
    // Reset release
    logic [1:0] rstPipe;            // Two-flop release
    logic       rstSyncB;           // Synchronised reset

    // Async assert, sync release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncB = rstPipe[1];

    // ========================================================
    // Run permission
    logic clkOk;                    // Required clocks present
    logic debugHold;                // Frozen by debug halt

    // Master needs core clock; slow clock only when mode uses it
    always_comb begin
        clkOk = 1'b1;
        if (masterMode && !coreClkOn) begin
            clkOk = 1'b0;
        end
        if (slowNeeded && !slowClkOn) begin
            clkOk = 1'b0;
        end
        // Clocks are assumed set up by software beforehand
        debugHold = cpuHalted && dbgRunStop;
    end
    assign running = clkOk && !debugHold;

    // ========================================================
    // Write acceptance
    logic wrOk;                     // Write goes through

    // Guard blocks protected writes unless from debugger
    always_comb begin
        wrOk      = wrEn;
        wrRefused = 1'b0;
        if (wrEn && wrProtected && lockOn && !wrFromDebug) begin
            wrOk      = 1'b0;
            wrRefused = 1'b1;
        end
    end

    // ========================================================
    // Config shadow and synchroniser handshake
    scc_pkg::scc_sync_t syncState;
    scc_pkg::scc_sync_t next_syncState;
    logic [BAUD_W-1:0]  shadowBaud;
    logic [BAUD_W-1:0]  next_shadowBaud;
    logic [ADDR_W-1:0]  shadowAddr;
    logic [ADDR_W-1:0]  next_shadowAddr;
    logic [ADDR_W-1:0]  shadowMask;
    logic [ADDR_W-1:0]  next_shadowMask;
    logic               next_syncToggle;
    logic               echoSync;   // Echo after two flops
    logic [BAUD_W-1:0]  next_baudValue;
    logic [ADDR_W-1:0]  next_matchAddr;
    logic [ADDR_W-1:0]  next_matchMask;

    // Echo crosses back through two flops
    scc_sync_bit #(.W(1)) u_echo (
        .clk      (clk),
        .rstSyncB (rstSyncB),
        .async_in (syncEcho),
        .sync_out (echoSync)
    );

    // Writes land in shadow; a new write while busy is ignored
    // (trade-off: no queue, software polls busy before writing)
    always_comb begin
        next_syncState  = syncState;
        next_shadowBaud = shadowBaud;
        next_shadowAddr = shadowAddr;
        next_shadowMask = shadowMask;
        next_syncToggle = syncToggle;
        next_baudValue  = baudValue;
        next_matchAddr  = matchAddr;
        next_matchMask  = matchMask;
        case (syncState)
            scc_pkg::SCC_SYNC_IDLE: begin
                if (wrOk && (wrBaud || wrAddr)) begin
                    if (wrBaud) begin
                        next_shadowBaud = wrData[BAUD_W-1:0];
                    end else begin
                        next_shadowAddr = wrData[ADDR_W-1:0];
                        next_shadowMask = wrData[15:8];
                    end
                    next_syncToggle = ~syncToggle;
                    next_syncState  = scc_pkg::SCC_SYNC_REQ;
                end
            end
            scc_pkg::SCC_SYNC_REQ: begin
                if (echoSync == syncToggle) begin
                    next_baudValue = shadowBaud;
                    next_matchAddr = shadowAddr;
                    next_matchMask = shadowMask;
                    next_syncState = scc_pkg::SCC_SYNC_ACK;
                end
            end
            scc_pkg::SCC_SYNC_ACK: next_syncState = scc_pkg::SCC_SYNC_IDLE;
            default:               next_syncState = scc_pkg::SCC_SYNC_IDLE;
        endcase
    end

    // Register sync state and config
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            syncState  <= scc_pkg::SCC_SYNC_IDLE;
            shadowBaud <= scc_pkg::SCC_BAUD_RST;
            shadowAddr <= scc_pkg::SCC_ADDR_RST;
            shadowMask <= scc_pkg::SCC_ADDR_RST;
            syncToggle <= 1'b0;
            baudValue  <= scc_pkg::SCC_BAUD_RST;
            matchAddr  <= scc_pkg::SCC_ADDR_RST;
            matchMask  <= scc_pkg::SCC_ADDR_RST;
        end else begin
            syncState  <= next_syncState;
            shadowBaud <= next_shadowBaud;
            shadowAddr <= next_shadowAddr;
            shadowMask <= next_shadowMask;
            syncToggle <= next_syncToggle;
            baudValue  <= next_baudValue;
            matchAddr  <= next_matchAddr;
            matchMask  <= next_matchMask;
        end
    end

    // Busy until one cycle after the value is active
    assign syncBusy = (syncState != scc_pkg::SCC_SYNC_IDLE);

    // ========================================================
    // Baud relation
    logic [15:0] next_cpf;
    logic [15:0] frameLen;          // Data + start + first stop

    // Base is frame length times sixteen, plus one per step
    always_comb begin
        frameLen = 16'({12'h000, dataBits}) + 16'({14'h0000, framingBits});
        next_cpf = 16'(frameLen * scc_pkg::SCC_CPF_PER_BIT)
                 + 16'(baudValue / scc_pkg::SCC_BAUD_STEP);
        // Linear form is exact at the low end only
        if (baudValue == scc_pkg::SCC_BAUD_TOP) begin
            next_cpf = 16'(scc_pkg::SCC_CPF_MAX);
        end
    end

    // Registered output
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            cyclesPerFrame <= scc_pkg::SCC_CPF_RST;
        end else begin
            cyclesPerFrame <= next_cpf;
        end
    end

    // ========================================================
    // Address comparator
    logic next_addrMatch;

    // Decode a match for given mode and width
    function automatic logic scc_cmp(
        input scc_pkg::scc_match_t mode,
        input logic [7:0]          a,
        input logic [7:0]          ref0,
        input logic [7:0]          ref1,
        input logic [7:0]          wmask
    );
        logic r;
        r = 1'b0;
        case (mode)
            scc_pkg::SCC_MATCH_MASK:
                r = (((a ^ ref0) & ~ref1) & wmask) == 8'h00;
            scc_pkg::SCC_MATCH_TWO:  r = ((a & wmask) == (ref0 & wmask))
                         || ((a & wmask) == (ref1 & wmask));
            scc_pkg::SCC_MATCH_RANGE: r = ((a & wmask) >= (ref0 & wmask))
                         && ((a & wmask) <= (ref1 & wmask));
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Evaluate only when the core may run
    always_comb begin
        next_addrMatch = addrMatch;
        if (addrValid && running) begin
            next_addrMatch = scc_cmp(matchMode, 8'(rxAddr), 8'(matchAddr),
                8'(matchMask), sevenBit ? scc_pkg::SCC_SEVEN_MASK : 8'hFF);
        end
    end

    // ========================================================
    // Event requests
    logic next_dmaRx, next_dmaTx, next_irq;    // Gated event copies

    // Gate events with run permission
    always_comb begin
        next_dmaRx = dmaRxEvt && running;
        next_dmaTx = dmaTxEvt && running;
        next_irq   = irqEvt && running;
    end

    // Register results
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            addrMatch <= 1'b0;
            dmaRxReq  <= 1'b0;
            dmaTxReq  <= 1'b0;
            irqReq    <= 1'b0;
        end else begin
            addrMatch <= next_addrMatch;
            dmaRxReq  <= next_dmaRx;
            dmaTxReq  <= next_dmaTx;
            irqReq    <= next_irq;
        end
    end

endmodule

`default_nettype wire

// *** tb/scc_echo_model.sv ***
// Echo model standing in for the core clock domain of the serial unit.
// Assumes syncToggle is a level held until its echo comes back.
`timescale 1ns/10ps
`default_nettype none
module scc_echo_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Handshake
    input  wire logic slowEcho,    // Answer late, like a slow core clock
    input  wire logic syncToggle,  // Toggle from the bus side
    output var  logic syncEcho     // Echo once the value is taken
);
    // ========================================================
    // Echo delay
    int cnt;                       // Cycles spent on the pending toggle
    // The delay stands for the unknown ratio of the two clocks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncEcho <= 1'b0;
            cnt      <= 0;
        end else if (syncEcho != syncToggle) begin
            cnt <= cnt + 1;
            if (cnt >= (slowEcho ? 9 : 1)) begin
                syncEcho <= syncToggle;
                cnt      <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/scc_common_core_chk.sv ***
// Checker for the serial unit common core, bound to its top ports.
// Assumes one clk domain and the async active-low rst_b.
`timescale 1ns/10ps
`default_nettype none
module scc_common_core_chk #(
    parameter int ADDR_W = 8,
    parameter int BAUD_W = 16
) (
    // Clock, reset and clock presence
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              coreClkOn,
    input wire logic              masterMode,
    input wire logic              cpuHalted,
    input wire logic              dbgRunStop,
    // Writes and sync
    input wire logic              wrEn,
    input wire logic              wrFromDebug,
    input wire logic              wrProtected,
    input wire logic              lockOn,
    input wire logic              wrBaud,
    input wire logic              wrAddr,
    input wire logic              wrRefused,
    input wire logic              syncEcho,
    input wire logic              syncToggle,
    input wire logic              syncBusy,
    input wire logic [BAUD_W-1:0] baudValue,
    // Events and match
    input wire logic              dmaRxEvt,
    input wire logic              dmaRxReq,
    input wire logic              irqEvt,
    input wire logic              irqReq,
    input wire logic              running,
    input wire scc_pkg::scc_match_t matchMode,
    input wire logic              addrValid,
    input wire logic [ADDR_W-1:0] matchMask,
    input wire logic              addrMatch
);
    // ========================================================
    // Properties; past rst_b guards the two-flop reset release
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_master_clk;
        masterMode && !coreClkOn |-> !running;
    endproperty
    a_master_clk: assert property (p_master_clk)
        else $error("master ran without core clock");
    property p_dbg_halt;
        cpuHalted && dbgRunStop |-> !running;
    endproperty
    a_dbg_halt: assert property (p_dbg_halt)
        else $error("ran during debug halt");
    property p_lock;
        wrEn && wrProtected && lockOn && !wrFromDebug |-> wrRefused;
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked write not refused");
    property p_dbg_wr;
        wrEn && (wrFromDebug || !wrProtected) |-> !wrRefused;
    endproperty
    a_dbg_wr: assert property (p_dbg_wr)
        else $error("open write refused");
    property p_sync;
        $past(rst_b, 3) && wrEn && (wrBaud || wrAddr) && !wrRefused
            && !syncBusy |=> syncBusy && (syncToggle != $past(syncToggle));
    endproperty
    a_sync: assert property (p_sync)
        else $error("write did not start sync");
    property p_busy_wait;
        syncBusy && (syncEcho != syncToggle) |=> syncBusy;
    endproperty
    a_busy_wait: assert property (p_busy_wait)
        else $error("busy dropped early");
    property p_cfg_sync;
        $changed(baudValue) |-> $past(syncBusy);
    endproperty
    a_cfg_sync: assert property (p_cfg_sync)
        else $error("baud changed unsynced");
    property p_rx_req;
        $past(rst_b, 3) && running && dmaRxEvt |=> dmaRxReq;
    endproperty
    a_rx_req: assert property (p_rx_req)
        else $error("dma request missing");
    property p_irq;
        $past(rst_b, 3) && running && irqEvt |=> irqReq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing");
    property p_all_ones;
        $past(rst_b, 3) && addrValid && running && !syncBusy && &matchMask
            && matchMode == scc_pkg::SCC_MATCH_MASK |=> addrMatch;
    endproperty
    a_all_ones: assert property (p_all_ones)
        else $error("full mask missed");
    // Main scenarios reached
    c_write: cover property (wrEn && !wrRefused && !syncBusy);
    c_refuse: cover property (wrRefused);
    c_match: cover property (addrValid ##1 addrMatch);
endmodule
bind scc_common_core scc_common_core_chk #(.ADDR_W(ADDR_W), .BAUD_W(BAUD_W))
u_scc_common_core_chk (.clk(clk), .rst_b(rst_b), .coreClkOn(coreClkOn),
    .masterMode(masterMode), .cpuHalted(cpuHalted), .dbgRunStop(dbgRunStop),
    .wrEn(wrEn), .wrFromDebug(wrFromDebug), .wrProtected(wrProtected),
    .lockOn(lockOn), .wrBaud(wrBaud), .wrAddr(wrAddr), .wrRefused(wrRefused),
    .syncEcho(syncEcho), .syncToggle(syncToggle), .syncBusy(syncBusy),
    .baudValue(baudValue), .dmaRxEvt(dmaRxEvt), .dmaRxReq(dmaRxReq),
    .irqEvt(irqEvt), .irqReq(irqReq), .running(running),
    .matchMode(matchMode), .addrValid(addrValid), .matchMask(matchMask),
    .addrMatch(addrMatch));
`default_nettype wire

// *** tb/scc_common_core_tb.sv ***
// Self-checking bench for the serial unit common core.
// Assumes the echo model stands in for the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module scc_common_core_tb;
    // ========================================================
    // Signals, model state and counters
    logic        clk, rst_b, coreClkOn, slowClkOn, masterMode, slowNeeded;
    logic        cpuHalted, dbgRunStop, wrEn, wrFromDebug, wrProtected;
    logic        lockOn, wrBaud, wrAddr, sevenBit, addrValid, echoSlow;
    logic        dmaRxEvt, dmaTxEvt, irqEvt, syncEcho, wrRefused, syncToggle;
    logic        syncBusy, addrMatch, running, dmaRxReq, dmaTxReq, irqReq;
    logic [15:0] wrData, cyclesPerFrame, baudValue, cfg;
    logic [7:0]  rxAddr, matchAddr, matchMask, ad, mk, a;
    logic [3:0]  dataBits;
    logic [1:0]  framingBits;
    scc_pkg::scc_match_t matchMode;
    int          mBaud, mAddr, mMask, fail_count, comparisons;
    // Run cases: master, core, slowNeed, slow, halted, stop, expected run
    logic [6:0]  runCase [6] = '{7'h79, 7'h48, 7'h30, 7'h21, 7'h2D, 7'h2E};
    // ========================================================
    // Design, far side and clock
    scc_common_core u_scc_common_core (.clk(clk), .rst_b(rst_b),
        .coreClkOn(coreClkOn), .slowClkOn(slowClkOn), .masterMode(masterMode),
        .slowNeeded(slowNeeded), .cpuHalted(cpuHalted), .dbgRunStop(dbgRunStop),
        .wrEn(wrEn), .wrFromDebug(wrFromDebug), .wrProtected(wrProtected),
        .lockOn(lockOn), .wrBaud(wrBaud), .wrAddr(wrAddr), .wrData(wrData),
        .wrRefused(wrRefused), .syncEcho(syncEcho), .syncToggle(syncToggle),
        .syncBusy(syncBusy), .dataBits(dataBits), .framingBits(framingBits),
        .cyclesPerFrame(cyclesPerFrame), .matchMode(matchMode),
        .sevenBit(sevenBit), .addrValid(addrValid), .rxAddr(rxAddr),
        .addrMatch(addrMatch), .dmaRxEvt(dmaRxEvt), .dmaTxEvt(dmaTxEvt),
        .irqEvt(irqEvt), .dmaRxReq(dmaRxReq), .dmaTxReq(dmaTxReq),
        .irqReq(irqReq), .running(running), .baudValue(baudValue),
        .matchAddr(matchAddr), .matchMask(matchMask));
    scc_echo_model u_scc_echo_model (.clk(clk), .rst_b(rst_b),
        .slowEcho(echoSlow), .syncToggle(syncToggle), .syncEcho(syncEcho));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ========================================================
    // Reference model and shared tasks
    function automatic int cycles_per_frame(int b, int d, int f);
        return (b == 65208) ? 31969 : (d + f) * 16 + b / 407;
    endfunction
    function automatic bit hit(int md, int x, int ra, int rm, bit sev);
        int w;
        w = sev ? 127 : 255;
        if (md == 0) return ((x ^ ra) & ~rm & w) == 0;
        if (md == 1) return (x == ra) || (x == rm);
        return (x >= ra) && (x <= rm);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One write; protection, origin and echo speed are drawn at random
    task automatic wr(input logic b, input logic [15:0] d, input logic lk);
        int  n;
        logic dbg, prot, refd;
        dbg  = 1'($urandom);
        prot = 1'($urandom);
        refd = prot & lk & !dbg;
        @(posedge clk);
        {wrEn, wrBaud, wrAddr, wrData} <= {1'b1, b, !b, d};
        {wrFromDebug, wrProtected, lockOn} <= {dbg, prot, lk};
        echoSlow <= 1'($urandom);
        #1 chk("wrRefused", wrRefused, refd);
        @(posedge clk);
        wrEn <= 1'b0;
        #1 chk("syncBusy", syncBusy, !refd);
        n = 0;
        while (syncBusy !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        if (syncBusy !== 1'b0) begin
            chk("sync timeout", 32'h0, 32'h1);
            print_verdict();
        end
        if (!refd && b) mBaud = d;
        if (!refd && !b) {mMask, mAddr} = {24'h0, d[15:8], 24'h0, d[7:0]};
        chk("baudValue", baudValue, mBaud);
        chk("matchAddr", matchAddr, mAddr);
        chk("matchMask", matchMask, mMask);
    endtask
    task automatic baud_case(input logic [15:0] b, input logic [3:0] d,
                             input logic [1:0] f);
        wr(1'b1, b, 1'b0);
        @(posedge clk);
        {dataBits, framingBits} <= {d, f};
        repeat (3) @(posedge clk);
        #1 chk("cyclesPerFrame", cyclesPerFrame,
               cycles_per_frame(b, d, f));
    endtask
    // ========================================================
    // Main sequence
    initial begin
        {rst_b, masterMode, slowNeeded, cpuHalted, dbgRunStop} = 5'h00;
        {coreClkOn, slowClkOn} = 2'h3;
        {wrEn, wrFromDebug, wrProtected, lockOn, wrBaud, wrAddr} = 6'h00;
        {sevenBit, addrValid, echoSlow, dmaRxEvt, dmaTxEvt, irqEvt} = 6'h00;
        {wrData, rxAddr, dataBits, framingBits} = {16'h0, 8'h0, 4'h8, 2'h2};
        matchMode = scc_pkg::SCC_MATCH_MASK;
        {mBaud, mAddr, mMask, fail_count, comparisons} = '0;
        void'($urandom(32'hEEEA));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("reset baud", baudValue, scc_pkg::SCC_BAUD_RST);
        baud_case(16'd0, 4'h8, 2'h2);
        baud_case(16'd406, 4'h8, 2'h2);
        baud_case(16'd407, 4'h8, 2'h2);
        baud_case(16'd65208, 4'h8, 2'h2);
        repeat (4) baud_case(16'($urandom), 4'($urandom_range(9, 5)),
                             2'($urandom));
        repeat (6) wr(1'($urandom), 16'($urandom), 1'b1);
        for (int md = 0; md < 3; md++) begin
            for (int k = 0; k < 4; k++) begin
                cfg = 16'($urandom);
                ad  = cfg[7:0];
                mk  = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : cfg[15:8];
                wr(1'b0, {mk, ad}, 1'b0);
                @(posedge clk);
                matchMode <= scc_pkg::scc_match_t'(md);
                sevenBit  <= (md == 0) && (k == 3);
                for (int j = 0; j < 10; j++) begin
                    a = (j == 0) ? ad : (j == 1) ? mk : (j == 2) ? ad ^ 8'h80
                        : 8'($urandom);
                    @(posedge clk);
                    {addrValid, rxAddr} <= {1'b1, a};
                    @(posedge clk);
                    addrValid <= 1'b0;
                    #1 chk("addrMatch", addrMatch,
                           hit(md, a, ad, mk, sevenBit));
                end
            end
        end
        foreach (runCase[i]) begin
            @(posedge clk);
            {masterMode, coreClkOn, slowNeeded} <= runCase[i][6:4];
            {slowClkOn, cpuHalted, dbgRunStop} <= runCase[i][3:1];
            {dmaRxEvt, dmaTxEvt, irqEvt} <= i[0] ? 3'($urandom) : 3'h7;
            @(posedge clk);
            #1 chk("running", running, runCase[i][0]);
            chk("requests", {dmaRxReq, dmaTxReq, irqReq},
                {dmaRxEvt, dmaTxEvt, irqEvt} & {3{runCase[i][0]}});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
